// file: logic/plmd_pkg.sv
// Purpose: shared constants for the link mode and request decoder
// Assumes: one core clock at 25 MHz, Avalon-MM register access
// Notes:   register offsets are byte addresses of 32-bit words
package plmd_pkg;
  // register byte offsets
  localparam logic [3:0] PLMD_OFS_CTRL   = 4'h0;  // control: accel / concat enables
  localparam logic [3:0] PLMD_OFS_STAT   = 4'h4;  // status: mode, last request
  localparam logic [3:0] PLMD_OFS_CLKCFG = 4'h8;  // link clock divider settings
  localparam logic [3:0] PLMD_OFS_CNT    = 4'hc;  // null packet counter
  // control bit positions
  localparam int PLMD_CTRL_EAA = 0;  // enable_arb_accel
  localparam int PLMD_CTRL_EMC = 1;  // enable_multispeed_concat
  // link clock nominal rates in kHz
  localparam int PLMD_LEGACY_KHZ = 49152;
  localparam int PLMD_NEW_KHZ    = 98304;
  localparam int PLMD_TOL_PPM    = 100;
  // reset hold time
  localparam int PLMD_RST_MS     = 2;
  localparam int PLMD_CLK_KHZ    = 25000;
  localparam int PLMD_RST_CYC    = PLMD_RST_MS * PLMD_CLK_KHZ;
  // request framing
  localparam int PLMD_SHORT_LEN  = 7;
  localparam int PLMD_LONG_LEN   = 8;
  localparam logic [2:0] PLMD_SPD_S400 = 3'h2;  // highest legacy speed code
  // request types (leading bits)
  localparam logic [1:0] PLMD_REQ_BUS = 2'h1;
  localparam logic [1:0] PLMD_REQ_REG = 2'h2;
  // state of the request shifter
  typedef enum logic [1:0] {
    PLMD_IDLE = 2'b00,
    PLMD_SHIFT = 2'b01,
    PLMD_NULL  = 2'b10
  } plmd_st_t;
  // null packet symbols on the transmit side
  localparam logic [1:0] PLMD_TX_IDLE   = 2'h0;
  localparam logic [1:0] PLMD_TX_PREFIX = 2'h1;
  localparam logic [1:0] PLMD_TX_END    = 2'h2;
endpackage : plmd_pkg

// file: logic/plmd_clkgen.sv
// Purpose: link clock divider with per-mode phase increment
// Assumes: accumulator clocked by the core clock
// Notes:   ratio is software-set so the ppm budget is a system matter
`timescale 1ns/1ps
module plmd_clkgen #(
  parameter int ACC_W = 24
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [ACC_W-1:0] incr,
  output logic                  clk_out
);
  import plmd_pkg::*;
  typedef struct packed {
    logic [ACC_W-1:0] acc;  // phase accumulator
    logic             clk;  // registered output
  } plmd_cg_t;
  plmd_cg_t s_q, s_d;
  // phase accumulate; msb gives the clock
  always_comb begin
    s_d = s_q;
    s_d.acc = s_q.acc + incr;
    s_d.clk = s_q.acc[ACC_W-1];
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign clk_out = s_q.clk;
endmodule : plmd_clkgen

// file: logic/plmd_top.sv
// Purpose: link mode select, bus request decode, null packet on overspeed
// Assumes: requests arrive one bit a cycle on req_bit, framed by req_valid
// Notes:   bus answers after one wait cycle; every output leaves a flop
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module plmd_top #(
  parameter int ACC_W = 24
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // strap and power-management input; the alternate pmc mode is not built
  input  wire logic        link_interface_select,
  input  wire logic        link_clock_pmc_in,
  // serial requests from the link controller
  input  wire logic        req_bit,
  input  wire logic        req_valid,
  input  wire logic        req_long,
  // register bus
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // link side
  output logic             phy_link_clock_out,
  output logic             phy_status_interrupt_out,
  // decode results and transmit symbols
  output logic [1:0]       tx_symbol,
  output logic             req_done,
  output logic [2:0]       req_speed,
  output logic             arb_accel_on,
  output logic             concat_on
);
  import plmd_pkg::*;
  // whole module state; every output of the block is one of these bits,
  // so nothing combinational reaches a pin and the link controller sees
  // clean edges one cycle after the decision
  typedef struct packed {
    logic             mode_new;   // strap sampled after reset
    logic             strap_done; // strap caught once
    logic [1:0]       ctrl;       // enable bits
    logic [ACC_W-1:0] inc_leg;    // divider step, legacy
    logic [ACC_W-1:0] inc_new;    // divider step, new mode
    plmd_st_t         st;         // shifter state
    logic [7:0]       sh;         // collected request bits
    logic [3:0]       nbits;      // bits collected
    logic             lng;        // current request long
    logic [7:0]       last_req;   // last decoded request
    logic [2:0]       speed;      // decoded speed
    logic             done;       // decode strobe
    logic [1:0]       tx;         // transmit symbol
    logic [15:0]      nulls;      // overspeed count
    logic [31:0]      rdata;      // bus read data
    logic             wait_n;     // answer stage
    logic             wreq;       // registered waitrequest, high when idle
    logic             lclk;       // retimed link clock
    logic             irq;        // status interrupt, never raised
  } plmd_s_t;
  plmd_s_t s_q, s_d;  // present and next state
  logic    clk_div;   // raw divider msb, retimed before it leaves
  // speed code extraction shared by both request lengths;
  // the speed sits in the last bits of a frame, so a short frame
  // yields a two-bit code with its top bit forced low
  function automatic logic [2:0] spd_of(input logic [7:0] r, input logic lg);
    spd_of = lg ? r[2:0] : {1'b0, r[1:0]};
  endfunction : spd_of
  // divider: step picked by sampled mode
  // the core clock is far slower than the nominal link rates, so the
  // step is a software knob; holding the ppm budget is a system matter
  plmd_clkgen #(.ACC_W(ACC_W)) u_clk (
    .core_clk (core_clk),
    .rstn     (rstn),
    .incr     (s_q.mode_new ? s_q.inc_new : s_q.inc_leg),
    .clk_out  (clk_div)
  );
  // next state: one combinational pass builds the whole copy of the state,
  // starting from the present value so that untouched fields simply hold
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;  // strobe lasts one cycle
    // strap taken first cycle after reset, not during it; a strap that
    // moves later is ignored until the next reset, which keeps the link
    // clock from jumping between rates under a running controller
    if (!s_q.strap_done) begin
      s_d.mode_new = link_interface_select;
      s_d.strap_done = 1'b1;
    end
    // request shifter; a new frame may start in the cycle after a finish that sends no null packet
    unique case (s_q.st)
      // waiting for the first bit of a frame
      PLMD_IDLE: begin
        s_d.tx = PLMD_TX_IDLE;
        if (req_valid) begin
          s_d.st = PLMD_SHIFT;
          s_d.sh = {7'h00, req_bit};
          s_d.nbits = 4'h1;
          s_d.lng = req_long;
        end
      end
      // collecting bits msb first until the frame length is reached
      PLMD_SHIFT: begin
        if (req_valid) begin
          s_d.sh = {s_q.sh[6:0], req_bit};
          s_d.nbits = s_q.nbits + 4'h1;
          // length is fixed by the flag taken with the first bit
          if (s_q.nbits + 4'h1 == (s_q.lng ? 4'(PLMD_LONG_LEN) : 4'(PLMD_SHORT_LEN))) begin
            s_d.last_req = {s_q.sh[6:0], req_bit};
            s_d.speed = spd_of({s_q.sh[6:0], req_bit}, s_q.lng);
            s_d.done = 1'b1;
            s_d.st = PLMD_IDLE;  // free for the next request at once
            // overspeed in legacy mode gives an empty packet
            if (!s_q.mode_new && spd_of({s_q.sh[6:0], req_bit}, s_q.lng) > PLMD_SPD_S400) begin
              s_d.st = PLMD_NULL;
              s_d.tx = PLMD_TX_PREFIX;
              s_d.nulls = s_q.nulls + 16'h0001;
            end
          end
        end else begin
          s_d.st = PLMD_IDLE;  // broken frame dropped
        end
      end
      // second symbol of the empty packet; nothing may come between;
      // a first bit arriving in this cycle is lost, so the controller
      // must leave one idle cycle after an overspeed request
      PLMD_NULL: begin
        s_d.tx = PLMD_TX_END;  // end follows prefix directly
        s_d.st = PLMD_IDLE;
      end
      default: s_d.st = PLMD_IDLE;  // unused code recovers to idle
    endcase
    // retimed side outputs
    s_d.lclk = clk_div;
    s_d.irq = 1'b0;  // no isolation handshake, line stays low
    // avalon slave: waitrequest idles high and drops for one cycle.
    // read data is registered in the first cycle of a request, so it
    // already stands when the master sees waitrequest low; answering
    // in the first cycle would hand over stale data
    s_d.wait_n = 1'b0;  // answer stage lasts one cycle
    s_d.wreq = 1'b1;  // idle or first cycle: keep the master waiting
    if (avs_read || avs_write) begin
      if (!s_q.wait_n) begin
        // first cycle: latch read data, release the master next edge
        s_d.wait_n = 1'b1;
        s_d.wreq = 1'b0;
        unique case (avs_address)
          PLMD_OFS_CTRL:   s_d.rdata = {30'h0, s_q.ctrl};
          PLMD_OFS_STAT:   s_d.rdata = {20'h0, s_q.speed, s_q.mode_new, s_q.last_req};
          PLMD_OFS_CLKCFG: s_d.rdata = 32'(s_q.mode_new ? s_q.inc_new : s_q.inc_leg);
          PLMD_OFS_CNT:    s_d.rdata = {16'h0, s_q.nulls};
          default:         s_d.rdata = 32'h0;  // unmapped reads zero
        endcase
      end else if (avs_write) begin
        // answer cycle: a write lands at the edge that ends the answer cycle, one edge after the master is released
        unique case (avs_address)
          PLMD_OFS_CTRL: s_d.ctrl = avs_writedata[1:0];
          PLMD_OFS_CLKCFG: begin
            // only the step of the running mode is reachable
            if (s_q.mode_new) s_d.inc_new = avs_writedata[ACC_W-1:0];
            else s_d.inc_leg = avs_writedata[ACC_W-1:0];
          end
          default: ;  // read-only and unmapped offsets ignore writes
        endcase
      end
    end
  end
  // state register; reset loads constants only, the divider steps
  // start near the nominal ratios and are trimmed by software
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.inc_leg <= ACC_W'(24'h7dd2f1);  // about 49.152/25 scaled, tune in software
      s_q.inc_new <= ACC_W'(24'hfba5e3);
      s_q.wreq <= 1'b1;  // slave busy while reset is held
    end else begin
      s_q <= s_d;
    end
  end
  // outputs: every one is a bit of the state register, no logic behind it,
  // which costs one cycle of latency on the link clock and the bus answer
  assign phy_link_clock_out = s_q.lclk;
  assign phy_status_interrupt_out = s_q.irq;
  assign tx_symbol = s_q.tx;
  assign req_done = s_q.done;  // one-cycle strobe
  assign req_speed = s_q.speed;  // holds until the next decode
  assign arb_accel_on = s_q.ctrl[PLMD_CTRL_EAA];
  assign concat_on = s_q.ctrl[PLMD_CTRL_EMC];
  // bus answer
  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wreq;
endmodule : plmd_top

// file: tb/plmd_chk_assertions.sv
// Purpose: port checker for plmd_top
// Assumes: strap steady within one reset
// Notes:   bound from the bench top
`timescale 1ns/1ps
module plmd_chk import plmd_pkg::*; (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        link_interface_select,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  tx_symbol,
  input wire logic        req_done,
  input wire logic        req_valid,
  input wire logic [2:0]  req_speed,
  input wire logic        arb_accel_on,
  input wire logic        concat_on
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // granted write to the control word
  sequence s_ctrl_wr;
    avs_write && !avs_waitrequest && avs_address == PLMD_OFS_CTRL;
  endsequence
  // null packet: prefix then end, no payload
  sequence s_null;
    tx_symbol == PLMD_TX_PREFIX ##1 tx_symbol == PLMD_TX_END;
  endsequence
  property p_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_ans: assert property (p_ans) else $error("late answer");
  property p_eaa;
    s_ctrl_wr |=> arb_accel_on == $past(avs_writedata[PLMD_CTRL_EAA]);
  endproperty
  a_eaa: assert property (p_eaa) else $error("accel copy");
  property p_emc;
    s_ctrl_wr |=> concat_on == $past(avs_writedata[PLMD_CTRL_EMC]);
  endproperty
  a_emc: assert property (p_emc) else $error("concat copy");
  property p_pulse;
    req_done |=> !req_done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done too long");
  property p_cause;
    req_done |-> $past(req_valid);
  endproperty
  a_cause: assert property (p_cause) else $error("done without bits");
  property p_nseq;
    tx_symbol == PLMD_TX_PREFIX |-> s_null;
  endproperty
  a_nseq: assert property (p_nseq) else $error("bad null packet");
  property p_nmode;
    tx_symbol == PLMD_TX_PREFIX |-> !link_interface_select;
  endproperty
  a_nmode: assert property (p_nmode) else $error("null in new mode");
  property p_ntrig;
    req_done && req_speed > PLMD_SPD_S400 && !link_interface_select
      |-> ##[0:3] tx_symbol == PLMD_TX_PREFIX;
  endproperty
  a_ntrig: assert property (p_ntrig) else $error("no null packet");
endmodule : plmd_chk

// file: tb/plmd_link_model.sv
// Purpose: link controller model sending serial requests
// Assumes: runs off the block's own clock
// Notes:   idle data line toggles so no stale bit survives
`timescale 1ns/1ps
module plmd_link_model import plmd_pkg::*; (
  input wire logic       core_clk,
  input wire logic       go,
  input wire logic       is_long,
  input wire logic [2:0] spd,
  output logic           req_bit,
  output logic           req_valid,
  output logic           req_long
);
  logic [7:0] fr_q = 8'h00;  // frame left to send, msb first
  int         n_q  = 0;      // bits left
  logic       lg_q = 1'h0;   // length flag of this frame
  // one bit a cycle; a new frame may load on the last bit
  always @(posedge core_clk) begin
    if (n_q != 0) begin
      req_bit   <= fr_q[7];
      req_valid <= 1'h1;
      req_long  <= lg_q;
      fr_q      <= fr_q << 1;
      n_q       <= n_q - 1;
    end else begin
      req_valid <= 1'h0;
      req_bit   <= (req_bit === 1'h1) ? 1'h0 : 1'h1;  // released line toggles from power-up
    end
    if (go) begin
      // speed code closes the frame; a short frame sends bits 7..1 only
      fr_q <= is_long ? {PLMD_REQ_BUS, 3'h0, spd} : {PLMD_REQ_BUS, 3'h0, spd[1:0], 1'h0};
      n_q  <= is_long ? PLMD_LONG_LEN : PLMD_SHORT_LEN;
      lg_q <= is_long;
    end
  end
endmodule : plmd_link_model

// file: tb/test_phy_link_mode_request_decoder.sv
// Purpose: self-checking bench for plmd_top
// Assumes: 25 MHz clock, reset scaled to two cycles
// Notes:   link clock only checked for activity, its rate is software-set
`timescale 1ns/1ps
module test_phy_link_mode_request_decoder;
  import plmd_pkg::*;
  logic core_clk = 1'h0, rstn = 1'h0, link_interface_select = 1'h0, go = 1'h0, lng = 1'h0;
  logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, req_done, arb_accel_on, concat_on;
  logic req_bit, req_valid, req_long, irq, lclk;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [2:0]  spd = 3'h0, req_speed;
  logic [1:0]  tx_symbol;
  int          mismatches = 0, cmp_count = 0;
  always #20 core_clk = ~core_clk;
  plmd_top dut_u (.core_clk, .rstn, .link_interface_select, .link_clock_pmc_in(1'h0),
    .req_bit, .req_valid, .req_long, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .phy_link_clock_out(lclk), .phy_status_interrupt_out(irq),
    .tx_symbol, .req_done, .req_speed, .arb_accel_on, .concat_on);
  plmd_link_model link_u (.core_clk, .go, .is_long(lng), .spd, .req_bit, .req_valid, .req_long);
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // wait a bounded time: sel 0 for a decode strobe, 1 for a null prefix
  task automatic wait_on(input int sel, input int lim);
    int t = 0;
    while (((sel == 0) ? req_done : (tx_symbol == PLMD_TX_PREFIX)) !== 1'h1 && t < lim) begin
      @(posedge core_clk);
      t++;
    end
    if (t >= lim) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_on
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    int   n;
    n = 0;
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      ok = (avs_waitrequest === 1'h0);
      n++;
    end while (!ok && n < 50);
    if (!ok) begin
      mismatches++;
      report_and_stop();
    end
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask : bus
  task automatic rst(input logic s);
    rstn <= 1'h0;
    link_interface_select <= s;
    repeat (2) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (2) @(posedge core_clk);
  endtask : rst
  task automatic send(input logic l, input logic [2:0] s);
    go <= 1'h1;
    lng <= l;
    spd <= s;
    @(posedge core_clk);
    go <= 1'h0;
  endtask : send
  task automatic t_ctrl;
    bus(1'h1, PLMD_OFS_CTRL, 32'h3);
    repeat (2) @(posedge core_clk);
    chk("accel on", 1, arb_accel_on);
    chk("concat on", 1, concat_on);
    bus(1'h1, PLMD_OFS_CTRL, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("accel off", 0, arb_accel_on);
    chk("concat off", 0, concat_on);
    bus(1'h0, 4'h1, 32'h0);
    chk("unmapped", 0, q);
    chk("interrupt", 0, irq);
    bus(1'h1, PLMD_OFS_CLKCFG, 32'h0040_0000);
    bus(1'h0, PLMD_OFS_CLKCFG, 32'h0);
    chk("divider step", 32'h0040_0000, q);
    $display("control test done");
  endtask : t_ctrl
  // the link clock must run in either mode
  task automatic t_lclk;
    int   e;
    logic p;
    e = 0;
    p = lclk;
    repeat (64) begin
      @(posedge core_clk);
      if (lclk === 1'h1 && p === 1'h0) e++;
      p = lclk;
    end
    chk("link clock runs", 1, e > 0);
    $display("link clock test done");
  endtask : t_lclk
  task automatic t_legacy;
    send(1'h0, 3'h2);
    repeat (6) @(posedge core_clk);
    send(1'h1, 3'h4);
    wait_on(0, 40);
    chk("short speed", 3'h2, req_speed);
    @(posedge core_clk);
    wait_on(0, 40);
    chk("long speed", 3'h4, req_speed);
    wait_on(1, 4);
    chk("prefix", PLMD_TX_PREFIX, tx_symbol);
    @(posedge core_clk);
    chk("end", PLMD_TX_END, tx_symbol);
    bus(1'h0, PLMD_OFS_CNT, 32'h0);
    chk("null count", 1, q);
    bus(1'h0, PLMD_OFS_STAT, 32'h0);
    chk("status", {20'h0, 3'h4, 1'h0, PLMD_REQ_BUS, 3'h0, 3'h4}, q);
    $display("legacy test done");
  endtask : t_legacy
  task automatic t_new;
    send(1'h1, 3'h4);
    wait_on(0, 40);
    chk("new speed", 3'h4, req_speed);
    repeat (6) begin
      @(posedge core_clk);
      chk("no null", PLMD_TX_IDLE, tx_symbol);
    end
    $display("new mode test done");
  endtask : t_new
  initial begin
    rst(1'h0);
    t_ctrl();
    t_lclk();
    t_legacy();
    rst(1'h1);
    t_new();
    t_lclk();
    report_and_stop();
  end
endmodule : test_phy_link_mode_request_decoder
bind plmd_top plmd_chk chk_u (.core_clk, .rstn, .link_interface_select, .avs_read, .avs_write,
  .avs_address, .avs_writedata, .avs_waitrequest, .tx_symbol, .req_done, .req_valid,
  .req_speed, .arb_accel_on, .concat_on);
